// *** common/pscl_pkg.sv ***
// Constants and types shared by the strap configuration latch
package pscl_pkg;

    // Shared strap pin positions in the pin vectors
    localparam int PIN_AD0  = 0;
    localparam int PIN_AD1  = 1;
    localparam int PIN_AD2  = 2;
    localparam int PIN_CFG0 = 3;
    localparam int PIN_CFG1 = 4;
    localparam int PIN_CFG2 = 5;
    localparam int PIN_ANEG = 6;
    localparam int PIN_EMF  = 7;
    localparam int PIN_NUM  = 8;

    // Synchroniser lanes: the pins, then the irq strap, then energy detect
    localparam int SY_IRQ = 8;
    localparam int SY_ED  = 9;
    localparam int SY_NUM = 10;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL0  = 8'h00;
    localparam logic [7:0] OFS_STRAP  = 8'h04;
    localparam logic [7:0] OFS_POWER  = 8'h08;
    localparam logic [7:0] OFS_IRQCFG = 8'h0C;
    localparam logic [7:0] OFS_IRQST  = 8'h10;
    localparam logic [7:0] OFS_FILTER = 8'h14;

    // Control register 0 fields and reset value
    localparam int CTRL0_DUPLEX = 8;
    localparam int CTRL0_ANEG   = 12;
    localparam int CTRL0_SPEED  = 13;
    localparam logic [15:0] CTRL0_RST = 16'h2100;

    // Power control fields
    localparam int PWR_AUTO  = 0;
    localparam int PWR_SLEEP = 1;
    localparam int PWR_WAKE  = 2;

    // Interrupt configuration and status fields
    localparam int IRQ_POL_HIGH = 0;
    localparam int IRQ_MASK_SD  = 1;
    localparam int IRQ_MASK_SLP = 2;
    localparam int IST_SD       = 0;
    localparam int IST_SLP      = 1;

    // Filter control field
    localparam int FLT_DIS = 12;

    // Fixed upper management address bits
    localparam logic [1:0] ADDR_HI = 2'h0;

    // Mode strap codes
    typedef enum logic [2:0] {
        MODE_NORM_NOX = 3'b001,
        MODE_B2B_X    = 3'b101,
        MODE_NORM_X   = 3'b111
    } pscl_mode_t;

    // Capture sequencer states
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_CAPT  = 2'b01,
        ST_RUN   = 2'b10
    } pscl_state_t;

endpackage

// *** hw/pscl_sync.sv ***
// Three-flop input synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module pscl_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         ref_clk,
    // Asynchronous inputs and their filtered values
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] val_q;

    // No reset here: the lanes must keep tracking the pins during reset
    // so the straps are settled when reset is released.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            always_ff @(posedge ref_clk) begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    val_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = val_q;
endmodule

// *** hw/pscl_top.sv ***
// Strap-in configuration latch, shared pin control and management regs
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module pscl_top
    import pscl_pkg::*;
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // Shared strap pins
    input  wire logic [pscl_pkg::PIN_NUM-1:0] pin_in,
    output logic      [pscl_pkg::PIN_NUM-1:0] pin_out,
    output logic      [pscl_pkg::PIN_NUM-1:0] pin_oe_n,
    // Interrupt pin, also the test strap
    input  wire logic                   irq_in,
    output logic                        irq_out,
    output logic                        irq_oe_n,
    // Signal detect
    input  wire logic                   energy_detect_in,
    output logic                        signal_detect_out,
    // Receive path from the line side
    input  wire logic [1:0]             core_rxd,
    input  wire logic                   core_rx_valid,
    input  wire logic                   core_rx_error,
    // Transmit path from the host
    input  wire logic                   tx_en_in,
    input  wire logic [1:0]             txd_in,
    output logic                        core_tx_valid,
    output logic      [1:0]             core_txd,
    // Configuration results
    output logic      [4:0]             mgmt_addr,
    output logic                        crossover_en,
    output logic                        back_to_back,
    output logic                        mode_reserved,
    output logic                        auto_negotiation_disable_strap_en,
    output logic                        speed_100,
    output logic                        full_duplex,
    output logic                        gate_chain_test,
    output logic                        emission_filter_en,
    output logic                        deep_standby,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_we,
    input  wire logic                   reg_re,
    output logic      [31:0]            reg_rdata
);
    import pscl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisation
    logic [SY_NUM-1:0] sy;

    pscl_sync #(.W(SY_NUM)) u_sync (
        .ref_clk  (ref_clk),
        .async_in ({energy_detect_in, irq_in, pin_in}),
        .sync_out (sy)
    );

    ////////////////////////////////////////////////////////////////////
    // Capture sequencer
    pscl_state_t st_q;
    pscl_state_t st_d;
    wire         capture = (st_q == ST_CAPT);
    wire         running = (st_q == ST_RUN);

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_RESET: st_d = ST_CAPT;
            ST_CAPT:  st_d = ST_RUN;
            default:  st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strap capture
    logic [2:0] addr_q;
    logic [2:0] mode_q;
    logic       aneg_strap_q;
    logic       test_strap_q;
    logic       emf_strap_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            addr_q       <= 3'h1;
            mode_q       <= 3'h7;
            aneg_strap_q <= 1'b1;
            test_strap_q <= 1'b1;
            emf_strap_q  <= 1'b0;
        end else if (capture) begin
            addr_q       <= {sy[PIN_AD2], sy[PIN_AD1], sy[PIN_AD0]};
            mode_q       <= {sy[PIN_CFG2], sy[PIN_CFG1], sy[PIN_CFG0]};
            aneg_strap_q <= sy[PIN_ANEG];
            test_strap_q <= sy[SY_IRQ];
            emf_strap_q  <= sy[PIN_EMF];
        end
    end

    assign mgmt_addr = {ADDR_HI, addr_q};

    // reserved codes only flagged, never trusted
    wire mode_nox = (mode_q == MODE_NORM_NOX);
    wire mode_b2b = (mode_q == MODE_B2B_X);
    wire mode_nx  = (mode_q == MODE_NORM_X);
    assign crossover_en  = mode_b2b | mode_nx;
    assign back_to_back  = mode_b2b;
    assign mode_reserved = ~(mode_nox | mode_b2b | mode_nx);

    assign gate_chain_test = ~test_strap_q;

    ////////////////////////////////////////////////////////////////////
    // Register decode
    wire wr_ctrl0  = reg_we & (reg_addr == OFS_CTRL0);
    wire wr_power  = reg_we & (reg_addr == OFS_POWER);
    wire wr_irqcfg = reg_we & (reg_addr == OFS_IRQCFG);
    wire wr_filter = reg_we & (reg_addr == OFS_FILTER);
    wire rd_irqst  = reg_re & (reg_addr == OFS_IRQST);

    ////////////////////////////////////////////////////////////////////
    // Control register 0
    logic [15:0] ctrl0_q;

    // strap loaded into bit 12, then writable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl0_q <= CTRL0_RST;
        end else if (capture) begin
            ctrl0_q[CTRL0_ANEG] <= ~sy[PIN_ANEG];
        end else if (wr_ctrl0) begin
            ctrl0_q <= reg_wdata[15:0];
        end
    end

    assign auto_negotiation_disable_strap_en  = ctrl0_q[CTRL0_ANEG];
    assign speed_100   = ctrl0_q[CTRL0_SPEED];
    assign full_duplex = ctrl0_q[CTRL0_DUPLEX];

    ////////////////////////////////////////////////////////////////////
    // Emission filter: software may only turn it off
    logic flt_en_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            flt_en_q <= 1'b1;
        end else if (capture) begin
            flt_en_q <= ~sy[PIN_EMF];
        end else if (wr_filter && reg_wdata[FLT_DIS]) begin
            flt_en_q <= 1'b0;
        end
    end

    assign emission_filter_en = flt_en_q;

    ////////////////////////////////////////////////////////////////////
    // Signal detect and deep standby
    logic sd_q;
    logic auto_slp_q;
    logic slp_q;

    assign signal_detect_out = sd_q;

    wire sd_fall = sd_q & ~sy[SY_ED];
    wire sd_chg  = sd_q ^ sy[SY_ED];

    wire slp_set = (auto_slp_q & sd_fall)
                 | (wr_power & reg_wdata[PWR_SLEEP]);
    wire slp_clr = wr_power & reg_wdata[PWR_WAKE];

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sd_q       <= 1'b0;
            auto_slp_q <= 1'b0;
            slp_q      <= 1'b0;
        end else begin
            sd_q <= running ? sy[SY_ED] : 1'b0;
            if (wr_power) begin
                auto_slp_q <= reg_wdata[PWR_AUTO];
            end
            // Entry wins over a wake request in the same cycle
            if (running && slp_set) begin
                slp_q <= 1'b1;
            end else if (slp_clr) begin
                slp_q <= 1'b0;
            end
        end
    end

    assign deep_standby = slp_q;

    ////////////////////////////////////////////////////////////////////
    // Status change interrupt
    logic [2:0] irqcfg_q;
    logic [1:0] ist_q;
    logic       irq_q;

    wire [1:0] ev = {running & slp_set & ~slp_q, running & sd_chg};

    // sticky events, cleared by reading, set wins
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irqcfg_q <= 3'h0;
            ist_q    <= 2'h0;
            irq_q    <= 1'b0;
        end else begin
            if (wr_irqcfg) begin
                irqcfg_q <= reg_wdata[2:0];
            end
            ist_q <= ev | (rd_irqst ? 2'h0 : ist_q);
            irq_q <= (ist_q[IST_SD] & irqcfg_q[IRQ_MASK_SD])
                   | (ist_q[IST_SLP] & irqcfg_q[IRQ_MASK_SLP]);
        end
    end

    // active-low default is open-drain like, high drives both ways
    // released while reset or capture is under way
    always_comb begin
        irq_out  = 1'b0;
        irq_oe_n = 1'b1;
        if (running) begin
            if (irqcfg_q[IRQ_POL_HIGH]) begin
                irq_out  = irq_q;
                irq_oe_n = 1'b0;
            end else begin
                irq_oe_n = ~irq_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive and transmit paths
    logic [1:0] rxd_q;
    logic       rxdv_q;
    logic       receive_error_out_q;
    logic       txv_q;
    logic [1:0] txd_q;

    // registered, data only qualified by valid
    // host data taken only under transmit enable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rxd_q  <= 2'h0;
            rxdv_q <= 1'b0;
            receive_error_out_q <= 1'b0;
            txv_q  <= 1'b0;
            txd_q  <= 2'h0;
        end else begin
            rxdv_q <= core_rx_valid & running;
            rxd_q  <= (core_rx_valid & running) ? core_rxd : 2'h0;
            receive_error_out_q <= core_rx_error & running;
            txv_q  <= tx_en_in & running;
            txd_q  <= (tx_en_in & running) ? txd_in : 2'h0;
        end
    end

    assign core_tx_valid = txv_q;
    assign core_txd      = txd_q;

    ////////////////////////////////////////////////////////////////////
    // Shared pin drive
    // inputs with pulls during reset and the capture cycle, outputs afterwards
    // relies on the host keeping these lines free until release
    always_comb begin
        pin_out           = '0;
        pin_oe_n          = {PIN_NUM{~running}};
        pin_out[PIN_AD2]  = rxd_q[1];
        pin_out[PIN_ANEG] = rxd_q[0];
        pin_out[PIN_CFG2] = rxdv_q;
        pin_out[PIN_EMF]  = receive_error_out_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Register read, data in the cycle after the strobe
    wire [31:0] strap_word = {16'h0, mode_reserved, emf_strap_q,
                              test_strap_q, aneg_strap_q, 1'b0,
                              mode_q, 3'h0, mgmt_addr};
    wire [31:0] rd_mux =
        (reg_addr == OFS_CTRL0)  ? {16'h0, ctrl0_q} :
        (reg_addr == OFS_STRAP)  ? strap_word :
        (reg_addr == OFS_POWER)  ? {29'h0, 1'b0, slp_q, auto_slp_q} :
        (reg_addr == OFS_IRQCFG) ? {29'h0, irqcfg_q} :
        (reg_addr == OFS_IRQST)  ? {30'h0, ist_q} :
        (reg_addr == OFS_FILTER) ? {19'h0, ~flt_en_q, 12'h0} :
                                   32'h0;

    // every control and status register readable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_re ? rd_mux : 32'h0;
        end
    end
endmodule

// *** verification/pscl_mac_model.sv ***
// MAC-side partner: strap resistors, shared wire levels, transmit frames
`timescale 1ns/1ps
module pscl_mac_model (
    // Clock
    input  wire logic       ref_clk,
    // Shared pins
    input  wire logic [7:0] strap,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    output logic      [7:0] pin_in,
    input  wire logic       irq_strap,
    input  wire logic       irq_out,
    input  wire logic       irq_oe_n,
    output logic            irq_in,
    // Transmit
    input  wire logic       tx_go,
    output logic            tx_en_in,
    output logic      [1:0] txd_in
);
    logic [2:0] left_q = 3'h0;
    ////////////////////////////////////////////////////////////////
    // lines left undriven
    // The MAC never drives shared lines, so a released pin shows its resistor
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & strap);
    assign irq_in = irq_oe_n ? irq_strap : irq_out;
    ////////////////////////////////////////////////////////////////
    // data valid only with enable
    // Idle data toggles every cycle so any leak into the core shows up
    initial begin
        tx_en_in = 1'b0;
        txd_in = 2'h0;
    end
    always @(posedge ref_clk) begin
        if (left_q != 3'h0) begin
            tx_en_in <= 1'b1;
            txd_in   <= 2'(3'h4 - left_q);
            left_q   <= left_q - 3'h1;
        end else begin
            tx_en_in <= 1'b0;
            txd_in   <= ~txd_in;
            if (tx_go) begin
                left_q <= 3'h4;
            end
        end
    end
endmodule

// *** verification/pscl_top_chk.sv ***
// Port-level checks for the strap configuration latch
`timescale 1ns/1ps
module pscl_top_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Watched ports
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic        irq_in,
    input wire logic        energy_detect_in,
    input wire logic        signal_detect_out,
    input wire logic [1:0]  core_rxd,
    input wire logic        core_rx_valid,
    input wire logic        tx_en_in,
    input wire logic [1:0]  txd_in,
    input wire logic        core_tx_valid,
    input wire logic [1:0]  core_txd,
    input wire logic [4:0]  mgmt_addr,
    input wire logic        crossover_en,
    input wire logic        back_to_back,
    input wire logic        mode_reserved,
    input wire logic        auto_negotiation_disable_strap_en,
    input wire logic        gate_chain_test,
    input wire logic        reg_re,
    input wire logic [31:0] reg_rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_pins_released: assert property ($rose(rstn) |-> &pin_oe_n ##1 &pin_oe_n ##1 !(|pin_oe_n))
        else $error("shared pins not held released then driven");
    a_straps_held: assert property ($past(rstn, 3) |-> $stable({mgmt_addr, crossover_en,
        back_to_back, mode_reserved, gate_chain_test})) else $error("captured strap changed");
    a_addr_capture: assert property ($rose(rstn) |-> ##2 mgmt_addr == {2'h0, $past(pin_in[2:0], 2)})
        else $error("address not taken from straps");
    a_neg_capture: assert property ($rose(rstn) |-> ##2 auto_negotiation_disable_strap_en == !$past(pin_in[6], 2))
        else $error("negotiation strap not applied");
    a_test_capture: assert property ($rose(rstn) |-> ##2 gate_chain_test == !$past(irq_in, 2))
        else $error("test strap not applied");
    a_mode_decode: assert property (!(back_to_back && !crossover_en)
        && !(mode_reserved && (crossover_en || back_to_back))) else $error("bad mode decode");
    a_sd_follow: assert property ($fell(signal_detect_out) |-> !$past(energy_detect_in, 3))
        else $error("signal detect fell with energy present");
    a_rx_path: assert property (core_rx_valid && pin_oe_n == 8'h00 |=> pin_out[5]
        && {pin_out[2], pin_out[6]} == $past(core_rxd)) else $error("receive data not forwarded");
    a_tx_path: assert property (##1 core_tx_valid == $past(tx_en_in)
        && core_txd == ($past(tx_en_in) ? $past(txd_in) : 2'h0)) else $error("transmit mismatch");
    a_rdata_idle: assert property (!reg_re |=> reg_rdata == 32'h0000_0000)
        else $error("read data without read strobe");
    c_reserved: cover property (mode_reserved);
    c_sd_fall: cover property ($fell(signal_detect_out));
    c_tx: cover property (core_tx_valid);
endmodule

bind pscl_top pscl_top_chk pscl_top_chk_inst (.*);

// *** verification/tb_top.sv ***
// Self-checking bench for the strap configuration latch
`timescale 1ns/1ps
module tb_top;
    import pscl_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  strap = 8'h01;
    logic        irq_strap = 1'b1;
    logic        energy_detect_in = 1'b1;
    logic [1:0]  core_rxd = 2'h0;
    logic        core_rx_valid = 1'b0;
    logic        core_rx_error = 1'b0;
    logic        tx_go = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    int          failures = 0;
    int          check_count = 0;
    logic [7:0]  pin_in, pin_out, pin_oe_n;
    logic [4:0]  mgmt_addr;
    logic [1:0]  txd_in, core_txd;
    logic [31:0] reg_rdata;
    logic        irq_in, irq_out, irq_oe_n, signal_detect_out, tx_en_in, core_tx_valid;
    logic        crossover_en, back_to_back, mode_reserved, auto_negotiation_disable_strap_en, speed_100;
    logic        full_duplex, gate_chain_test, emission_filter_en, deep_standby;

    pscl_top pscl_top_inst (.*);
    pscl_mac_model pscl_mac_model_inst (.*);

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic do_reset(input logic [7:0] s, input logic q);
        @(posedge ref_clk);
        strap     <= s;
        irq_strap <= q;
        rstn      <= 1'b0;
        wait_cyc(10);
        chk({24'h0, pin_oe_n}, 32'h0000_00FF);
        @(posedge ref_clk);
        rstn <= 1'b1;
        wait_cyc(3);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_straps();
        logic [2:0] modes [4] = '{3'h1, 3'h5, 3'h7, 3'h0};
        logic [2:0] xbr [4] = '{3'h0, 3'h6, 3'h4, 3'h1};
        logic [2:0] a;
        logic       n;
        logic       f;
        for (int i = 0; i < 4; i++) begin
            a = 3'(2 * i + 1);
            n = i[0];
            f = i[0] ^ i[1];
            do_reset({f, n, modes[i], a}, n);
            chk(32'({mgmt_addr, crossover_en, back_to_back, mode_reserved, auto_negotiation_disable_strap_en,
                gate_chain_test, emission_filter_en}),
                32'({2'h0, a, xbr[i], !n, !n, !f}));
            chk(32'({speed_100, full_duplex}),
                32'({CTRL0_RST[CTRL0_SPEED], CTRL0_RST[CTRL0_DUPLEX]}));
            rdc(OFS_STRAP, 32'({xbr[i][0], f, n, n, 1'b0, modes[i], 5'h0, a}));
            rdc(OFS_CTRL0, {16'h0, CTRL0_RST[15:13], !n, CTRL0_RST[11:0]});
            // Software may later override the strapped negotiation bit
            wr(OFS_CTRL0, 32'h0000_1000);
            #1;
            chk(32'({auto_negotiation_disable_strap_en, speed_100, full_duplex}), 32'h0000_0004);
            wr(OFS_STRAP, 32'hFFFF_FFFF);
            rdc(OFS_STRAP, 32'({xbr[i][0], f, n, n, 1'b0, modes[i], 5'h0, a}));
            rdc(8'h40, 32'h0000_0000);
            @(posedge ref_clk);
            irq_strap <= !n;
            wait_cyc(8);
            chk(32'(gate_chain_test), 32'(!n));
        end
        $display("strap capture test done");
    endtask
    task automatic t_rxtx();
        @(posedge ref_clk);
        core_rxd      <= 2'h2;
        core_rx_valid <= 1'b1;
        core_rx_error <= 1'b1;
        @(posedge ref_clk);
        core_rx_valid <= 1'b0;
        core_rx_error <= 1'b0;
        #1;
        chk({28'h0, pin_out[7], pin_out[6], pin_out[5], pin_out[2]}, 32'h0000_000B);
        wait_cyc(1);
        chk({28'h0, pin_out[7], pin_out[6], pin_out[5], pin_out[2]}, 32'h0000_0000);
        @(posedge ref_clk);
        tx_go <= 1'b1;
        @(posedge ref_clk);
        tx_go <= 1'b0;
        wait_cyc(2);
        for (int k = 0; k < 4; k++) begin
            chk({29'h0, core_tx_valid, core_txd}, 32'(4 + k));
            wait_cyc(1);
        end
        chk({29'h0, core_tx_valid, core_txd}, 32'h0000_0000);
        $display("receive and transmit test done");
    endtask
    task automatic t_standby();
        wr(OFS_IRQCFG, 32'h0000_0006);
        wr(OFS_POWER, 32'h0000_0001);
        @(posedge ref_clk);
        energy_detect_in <= 1'b0;
        wait_cyc(8);
        chk({29'h0, signal_detect_out, deep_standby, irq_oe_n}, 32'h0000_0002);
        chk(32'(irq_out), 32'h0000_0000);
        rdc(OFS_IRQST, 32'h0000_0003);
        rdc(OFS_IRQST, 32'h0000_0000);
        chk(32'(irq_oe_n), 32'h0000_0001);
        @(posedge ref_clk);
        energy_detect_in <= 1'b1;
        wait_cyc(8);
        wr(OFS_POWER, 32'h0000_0004);
        #1;
        chk(32'(deep_standby), 32'h0000_0000);
        wr(OFS_POWER, 32'h0000_0002);
        #1;
        chk({30'h0, signal_detect_out, deep_standby}, 32'h0000_0003);
        rdc(OFS_POWER, 32'h0000_0002);
        wr(OFS_IRQCFG, 32'h0000_0007);
        #1;
        chk({30'h0, irq_oe_n, irq_out}, 32'h0000_0001);
        rdc(OFS_IRQST, 32'h0000_0003);
        wait_cyc(2);
        chk({30'h0, irq_oe_n, irq_out}, 32'h0000_0000);
        wr(OFS_POWER, 32'h0000_0004);
        wr(OFS_FILTER, 32'h0000_1000);
        wr(OFS_FILTER, 32'h0000_0000);
        #1;
        chk({30'h0, deep_standby, emission_filter_en}, 32'h0000_0000);
        rdc(OFS_FILTER, 32'h0000_1000);
        rdc(OFS_IRQCFG, 32'h0000_0007);
        $display("standby and interrupt test done");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        complete_run();
    end
    initial begin
        t_straps();
        t_rxtx();
        t_standby();
        complete_run();
    end
endmodule
